// ==== cond_field_update_logic.sv ====
// condition field generation, summary overflow and general registers
`timescale 1ns/10ps
`include "cond_defs.svh"
module cond_field_update_logic (
    input  wire logic                                 clock,
    input  wire logic                                 rst_n,
    input  wire cond_pkg::exec_req_t                  exec_req,
    input  wire logic                                 so_clear,
    input  wire logic [`GPR_ADDR_W-1:0]               gpr_rd_addr,
    output logic      [`DATA_W-1:0]                   gpr_rd_data,
    output cond_pkg::cond_field_t [`FIELD_COUNT-1:0]  condition_reg,
    output logic                                      summary_overflow,
    output logic                                      overflow_flag,
    output logic                                      cf_update_done
);
    ////////////////////////////////////////////////////////////////////////
    // all state of this module except the register array in one word
    typedef struct packed {
        logic                                    s1_valid;   // stage one busy
        cond_pkg::op_kind_t                      s1_kind;    // held op kind
        logic                                    s1_special; // own-rule forms
        logic [`DATA_W-1:0]                      s1_result;  // written result
        logic                                    s1_ovf;     // overflow seen
        logic                                    s1_oe;      // overflow form
        logic [`FIELD_SEL_W-1:0]                 s1_tf;      // target field
        logic                                    s1_use_imm; // immediate b
        logic [`DATA_W-1:0]                      s1_imm;     // immediate value
        cond_pkg::cond_field_t [`FIELD_COUNT-1:0] cf;        // condition reg
        logic                                    so;         // summary ovf
        logic                                    ovr;        // last overflow
        logic                                    done;       // update pulse
    } state_t;

    state_t st_ff;  // registered state
    state_t nxt_st; // next state

    // register file read data, registered inside the array
    logic [`RD_PORTS-1:0][`GPR_ADDR_W-1:0] rd_addr;
    logic [`RD_PORTS-1:0][`DATA_W-1:0]     rd_data;
    logic [`DATA_W-1:0]                    cmp_a;  // first compare operand
    logic [`DATA_W-1:0]                    cmp_b;  // second compare operand

    ////////////////////////////////////////////////////////////////////////
    // signed result against zero; flags follow the truncated word only
    function automatic cond_pkg::cond_field_t zero_cmp(
        input logic [`DATA_W-1:0] res,
        input logic               so_val
    );
        cond_pkg::cond_field_t f;
        f.less_flag    = res[`SIGN_POS];
        f.greater_flag = (res != `RESET_WORD) && !res[`SIGN_POS];
        f.equal_flag   = (res == `RESET_WORD);
        f.so_copy      = so_val;
        return f;
    endfunction

    // two-operand compare, signed or unsigned by the caller's choice
    function automatic cond_pkg::cond_field_t op_cmp(
        input logic [`DATA_W-1:0] a,
        input logic [`DATA_W-1:0] b,
        input logic               sgn,
        input logic               so_val
    );
        cond_pkg::cond_field_t f;
        logic lt;
        logic gt;
        lt = sgn ? ($signed(a) < $signed(b)) : (a < b);
        gt = sgn ? ($signed(a) > $signed(b)) : (a > b);
        f.less_flag    = lt;
        f.greater_flag = gt;
        f.equal_flag   = (a == b);
        f.so_copy      = so_val;
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register array; operands read in the request cycle
    always_comb begin
        rd_addr[`PORT_CMP_A] = exec_req.src_a;
        rd_addr[`PORT_CMP_B] = exec_req.src_b;
        rd_addr[`PORT_EXT]   = gpr_rd_addr;
    end

    gpr_mem u_gpr (
        .clock   (clock),
        .rst_n   (rst_n),
        .wr_en   (exec_req.valid && exec_req.wr_en),
        .wr_addr (exec_req.wr_addr),
        .wr_data (exec_req.result),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // operand b is the immediate or a second register
    always_comb begin
        cmp_a = rd_data[`PORT_CMP_A];
        cmp_b = st_ff.s1_use_imm ? st_ff.s1_imm : rd_data[`PORT_CMP_B];
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: capture request, then update flags one cycle later
    always_comb begin
        nxt_st = st_ff; // fields not written below hold their value
        nxt_st.done = 1'b0;
        // stage one capture
        nxt_st.s1_valid   = exec_req.valid;
        nxt_st.s1_kind    = exec_req.valid ? exec_req.kind : cond_pkg::OP_NONE;
        nxt_st.s1_special = exec_req.special;
        nxt_st.s1_result  = exec_req.result;
        nxt_st.s1_ovf     = exec_req.ovf;
        nxt_st.s1_oe      = exec_req.oe;
        nxt_st.s1_tf      = exec_req.target_field_select;
        nxt_st.s1_use_imm = exec_req.use_imm;
        nxt_st.s1_imm     = exec_req.imm;

        // summary overflow: explicit clear loses to a same-cycle set
        if (so_clear) begin
            nxt_st.so = 1'b0;
        end
        if (st_ff.s1_valid && st_ff.s1_oe) begin
            // overflow is only recorded by overflow-form instructions
            nxt_st.ovr = st_ff.s1_ovf;
            if (st_ff.s1_ovf) begin
                nxt_st.so = 1'b1;
            end
        end

        // flag update uses summary overflow after this instruction
        if (st_ff.s1_valid) begin
            case (st_ff.s1_kind)
                cond_pkg::OP_RECORD: begin
                    // special record forms leave the field to their own logic
                    if (!st_ff.s1_special) begin
                        nxt_st.cf[0] = zero_cmp(st_ff.s1_result, nxt_st.so);
                        nxt_st.done  = 1'b1;
                    end
                end
                cond_pkg::OP_CMP_SGN: begin
                    nxt_st.cf[st_ff.s1_tf] = op_cmp(cmp_a, cmp_b, 1'b1, nxt_st.so);
                    nxt_st.done = 1'b1;
                end
                cond_pkg::OP_CMP_UNS: begin
                    nxt_st.cf[st_ff.s1_tf] = op_cmp(cmp_a, cmp_b, 1'b0, nxt_st.so);
                    nxt_st.done = 1'b1;
                end
                default: begin
                    // other fields are never written here
                    nxt_st.done = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, synchronous reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_ff.s1_valid   <= 1'b0;
            st_ff.s1_kind    <= cond_pkg::OP_NONE;
            st_ff.s1_special <= 1'b0;
            st_ff.s1_result  <= `RESET_WORD;
            st_ff.s1_ovf     <= 1'b0;
            st_ff.s1_oe      <= 1'b0;
            st_ff.s1_tf      <= '0;
            st_ff.s1_use_imm <= 1'b0;
            st_ff.s1_imm     <= `RESET_WORD;
            st_ff.cf         <= {`FIELD_COUNT{`RESET_FIELD}};
            st_ff.so         <= `RESET_SO;
            st_ff.ovr        <= `RESET_OV;
            st_ff.done       <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flip-flops
    assign condition_reg    = st_ff.cf;
    assign summary_overflow = st_ff.so;
    assign overflow_flag    = st_ff.ovr;
    assign cf_update_done   = st_ff.done;
    assign gpr_rd_data      = rd_data[`PORT_EXT];

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic rec_go; // a generic record-form update is in stage one
    logic cmp_go; // a compare is in stage one
    assign rec_go = st_ff.s1_valid && st_ff.s1_kind == cond_pkg::OP_RECORD
                    && !st_ff.s1_special;
    assign cmp_go = st_ff.s1_valid && (st_ff.s1_kind == cond_pkg::OP_CMP_SGN
                    || st_ff.s1_kind == cond_pkg::OP_CMP_UNS);

    property p_rec_less;
        @(posedge clock) disable iff (!rst_n)
        rec_go |=> condition_reg[0].less_flag == $past(st_ff.s1_result[`SIGN_POS]);
    endproperty
    a_rec_less: assert property (p_rec_less) else $error("less flag wrong");

    property p_rec_greater;
        @(posedge clock) disable iff (!rst_n)
        rec_go |=> condition_reg[0].greater_flag ==
                   ($past(st_ff.s1_result) != 0 && !$past(st_ff.s1_result[`SIGN_POS]));
    endproperty
    a_rec_greater: assert property (p_rec_greater) else $error("greater flag wrong");

    property p_rec_equal;
        @(posedge clock) disable iff (!rst_n)
        rec_go |=> condition_reg[0].equal_flag == ($past(st_ff.s1_result) == 0)
                   && cf_update_done;
    endproperty
    a_rec_equal: assert property (p_rec_equal) else $error("equal flag wrong");

    property p_so_copy;
        @(posedge clock) disable iff (!rst_n)
        (rec_go && st_ff.s1_oe && st_ff.s1_ovf) |=> condition_reg[0].so_copy
                                                   && summary_overflow;
    endproperty
    a_so_copy: assert property (p_so_copy) else $error("summary copy stale");

    property p_no_oe_keeps_so;
        @(posedge clock) disable iff (!rst_n)
        (st_ff.s1_valid && !st_ff.s1_oe && !so_clear) |=>
            summary_overflow == $past(summary_overflow);
    endproperty
    a_no_oe_keeps_so: assert property (p_no_oe_keeps_so) else $error("summary moved");

    property p_so_sticky;
        @(posedge clock) disable iff (!rst_n)
        (summary_overflow && !so_clear) |=> summary_overflow [*1];
    endproperty
    a_so_sticky: assert property (p_so_sticky) else $error("summary not sticky");

    property p_special_skip;
        @(posedge clock) disable iff (!rst_n)
        (st_ff.s1_valid && st_ff.s1_special && st_ff.s1_kind == cond_pkg::OP_RECORD)
            |=> $stable(condition_reg) && !cf_update_done;
    endproperty
    a_special_skip: assert property (p_special_skip) else $error("special updated");

    property p_rec_others_kept;
        @(posedge clock) disable iff (!rst_n)
        rec_go |=> condition_reg[`FIELD_COUNT-1:1] == $past(condition_reg[`FIELD_COUNT-1:1]);
    endproperty
    a_rec_others_kept: assert property (p_rec_others_kept) else $error("field clobbered");

    property p_cmp_equal;
        @(posedge clock) disable iff (!rst_n)
        cmp_go |=> condition_reg[$past(st_ff.s1_tf)].equal_flag == $past(cmp_a == cmp_b);
    endproperty
    a_cmp_equal: assert property (p_cmp_equal) else $error("compare equal wrong");

    property p_cmp_less;
        @(posedge clock) disable iff (!rst_n)
        cmp_go |=> condition_reg[$past(st_ff.s1_tf)].less_flag ==
            $past(st_ff.s1_kind == cond_pkg::OP_CMP_SGN ? $signed(cmp_a) < $signed(cmp_b)
                                                        : cmp_a < cmp_b);
    endproperty
    a_cmp_less: assert property (p_cmp_less) else $error("compare order wrong");

    property p_gpr_rw;
        @(posedge clock) disable iff (!rst_n)
        (exec_req.valid && exec_req.wr_en && exec_req.wr_addr == gpr_rd_addr)
            |=> gpr_rd_data == $past(exec_req.result);
    endproperty
    a_gpr_rw: assert property (p_gpr_rw) else $error("register read wrong");

    property p_cmp_greater;
        @(posedge clock) disable iff (!rst_n)
        cmp_go |=> condition_reg[$past(st_ff.s1_tf)].greater_flag ==
            $past(st_ff.s1_kind == cond_pkg::OP_CMP_SGN ? $signed(cmp_a) > $signed(cmp_b)
                                                        : cmp_a > cmp_b);
    endproperty
    a_cmp_greater: assert property (p_cmp_greater) else $error("greater wrong");

    property p_cmp_so_copy;
        @(posedge clock) disable iff (!rst_n)
        cmp_go |=> condition_reg[$past(st_ff.s1_tf)].so_copy == summary_overflow
                   && cf_update_done;
    endproperty
    a_cmp_so_copy: assert property (p_cmp_so_copy) else $error("compare copy wrong");

    // only the addressed nibble of the condition word may move on a compare
    property p_cmp_kept;
        @(posedge clock) disable iff (!rst_n)
        cmp_go |=> ((condition_reg ^ $past(condition_reg))
                   & ~(32'h0000_000f << {$past(st_ff.s1_tf), 2'b00})) == 32'h0000_0000;
    endproperty
    a_cmp_kept: assert property (p_cmp_kept) else $error("field clobbered");

    property p_ovr_kept;
        @(posedge clock) disable iff (!rst_n)
        !(st_ff.s1_valid && st_ff.s1_oe) |=> $stable(overflow_flag);
    endproperty
    a_ovr_kept: assert property (p_ovr_kept) else $error("overflow moved");

    property p_idle_quiet;
        @(posedge clock) disable iff (!rst_n)
        !(rec_go || cmp_go) |=> $stable(condition_reg) && !cf_update_done;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("field moved while idle");

    c_rec_zero: cover property (@(posedge clock) disable iff (!rst_n)
        rec_go && st_ff.s1_result == 0);
    c_cmp_sgn: cover property (@(posedge clock) disable iff (!rst_n)
        cmp_go && st_ff.s1_kind == cond_pkg::OP_CMP_SGN && st_ff.s1_tf != 0);
    c_cmp_uns: cover property (@(posedge clock) disable iff (!rst_n)
        cmp_go && st_ff.s1_kind == cond_pkg::OP_CMP_UNS);
    c_so_set: cover property (@(posedge clock) disable iff (!rst_n)
        !summary_overflow ##1 summary_overflow);
endmodule

// ==== cond_defs.svh ====
// constants for the condition field update logic
//
// Notes on behaviour
// - record forms compare written result with zero
// - less flag equals result sign bit
// - greater flag: nonzero result, sign clear
// - equal flag set only for zero result
// - bit zero takes summary overflow after update
// - overflow without overflow form leaves summary alone
// - flags follow truncated result, not true value
// - special record forms skip generic zero compare
// - compare register with immediate or register
// - arithmetic compares signed, logical compares unsigned
// - three-bit selector picks compare target field
// - compare sets less, greater, equal, summary copy
// - thirty-two general registers, thirty-two bits each
// - general registers need no privilege check
// - summary overflow sticky once overflow sets it
`ifndef COND_DEFS_SVH
`define COND_DEFS_SVH
`define DATA_W       32
`define SIGN_POS     31
`define GPR_COUNT    32
`define GPR_ADDR_W   5
`define FIELD_COUNT  8
`define FIELD_SEL_W  3
`define RD_PORTS     3
`define PORT_CMP_A   0
`define PORT_CMP_B   1
`define PORT_EXT     2
`define RESET_FIELD  4'h0
`define RESET_SO     1'b0
`define RESET_OV     1'b0
`define RESET_WORD   32'h0000_0000
`endif

// ==== cond_pkg.sv ====
// types shared by the condition field update logic, the issue model and the bench
`include "cond_defs.svh"
package cond_pkg;
    // kind of work presented by the issue pipeline, one-hot
    typedef enum logic [3:0] {
        OP_NONE     = 4'h1,
        OP_RECORD   = 4'h2,
        OP_CMP_SGN  = 4'h4,
        OP_CMP_UNS  = 4'h8
    } op_kind_t;

    // one condition field, first member is field bit 3
    typedef struct packed {
        logic less_flag;
        logic greater_flag;
        logic equal_flag;
        logic so_copy;
    } cond_field_t;

    // request from the decode and issue pipeline
    typedef struct packed {
        logic                      valid;
        op_kind_t                  kind;
        logic                      special;
        logic                      wr_en;
        logic [`GPR_ADDR_W-1:0]    wr_addr;
        logic [`DATA_W-1:0]        result;
        logic                      ovf;
        logic                      oe;
        logic [`FIELD_SEL_W-1:0]   target_field_select;
        logic [`GPR_ADDR_W-1:0]    src_a;
        logic [`GPR_ADDR_W-1:0]    src_b;
        logic                      use_imm;
        logic [`DATA_W-1:0]        imm;
    } exec_req_t;
endpackage

// ==== gpr_mem.sv ====
// general register array with registered read ports
`timescale 1ns/10ps
`include "cond_defs.svh"
module gpr_mem (
    input  wire logic                                   clock,
    input  wire logic                                   rst_n,
    input  wire logic                                   wr_en,
    input  wire logic [`GPR_ADDR_W-1:0]                 wr_addr,
    input  wire logic [`DATA_W-1:0]                     wr_data,
    input  wire logic [`RD_PORTS-1:0][`GPR_ADDR_W-1:0]  rd_addr,
    output logic      [`RD_PORTS-1:0][`DATA_W-1:0]      rd_data
);
    // storage, no reset: contents are undefined until software writes
    logic [`DATA_W-1:0] general_register_array [`GPR_COUNT];
    logic [`RD_PORTS-1:0][`DATA_W-1:0] rd_data_ff;

    ////////////////////////////////////////////////////////////////////////
    // single write port, open to every privilege level
    always_ff @(posedge clock) begin
        if (wr_en) begin
            general_register_array[wr_addr] <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read ports pass a same-cycle write through, so a compare right
    // behind its producer never sees stale data
    genvar p;
    generate
        for (p = 0; p < `RD_PORTS; p = p + 1) begin : g_rd
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    rd_data_ff[p] <= `RESET_WORD;
                end else if (wr_en && wr_addr == rd_addr[p]) begin
                    rd_data_ff[p] <= wr_data;
                end else begin
                    rd_data_ff[p] <= general_register_array[rd_addr[p]];
                end
            end
        end
    endgenerate

    assign rd_data = rd_data_ff;
endmodule

// ==== issue_model.sv ====
// issue pipeline model that presents requests to the condition logic
`timescale 1ns/10ps
`include "cond_defs.svh"
module issue_model (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire cond_pkg::exec_req_t cmd,
    output cond_pkg::exec_req_t      exec_req
);
    logic [`DATA_W-1:0] noise_ff; // idle data pattern
    initial noise_ff = 32'h0f0f_3c3c;
    // idle data lines change every cycle, so a stale value is never trusted
    always @(posedge clock) noise_ff <= ~noise_ff;
    // nothing is presented in reset; idle cycles carry noise on result and imm, not old data
    always_comb begin
        exec_req = cmd;
        if (!rst_n || !cmd.valid) begin
            exec_req.valid  = 1'b0;
            exec_req.kind   = cond_pkg::OP_NONE;
            exec_req.result = noise_ff;
            exec_req.imm    = ~noise_ff;
        end
    end
endmodule

// ==== cond_field_update_logic_tb.sv ====
// self-checking bench for the condition field update logic
`timescale 1ns/10ps
`include "cond_defs.svh"
module cond_field_update_logic_tb;
    logic                                     clock;
    logic                                     rst_n;
    cond_pkg::exec_req_t                      cmd;      // bench request
    cond_pkg::exec_req_t                      exec_req; // as presented
    logic                                     so_clear;
    logic [`GPR_ADDR_W-1:0]                   gpr_rd_addr;
    logic [`DATA_W-1:0]                       gpr_rd_data;
    cond_pkg::cond_field_t [`FIELD_COUNT-1:0] condition_reg;
    logic                                     summary_overflow;
    logic                                     overflow_flag;
    logic                                     cf_update_done;
    // expected state
    logic [`DATA_W-1:0]                       gpr_m [`GPR_COUNT];
    logic                                     known_m [`GPR_COUNT];
    cond_pkg::cond_field_t [`FIELD_COUNT-1:0] cf_m;
    cond_pkg::exec_req_t                      s1;   // request in flight
    logic [`DATA_W-1:0]                       s1_a, s1_b, rd_m, lfsr_q, v;
    logic                                     so_m, ovr_m, done_m, rd_known, armed, c;
    cond_pkg::exec_req_t                      r;
    int                                       n_mismatch, check_count, i;

    initial clock = 1'b0;
    always #5 clock = ~clock;

    issue_model i_issue_model (.clock(clock), .rst_n(rst_n), .cmd(cmd), .exec_req(exec_req));
    cond_field_update_logic i_cond_field_update_logic (
        .clock           (clock),
        .rst_n           (rst_n),
        .exec_req        (exec_req),
        .so_clear        (so_clear),
        .gpr_rd_addr     (gpr_rd_addr),
        .gpr_rd_data     (gpr_rd_data),
        .condition_reg   (condition_reg),
        .summary_overflow(summary_overflow),
        .overflow_flag   (overflow_flag),
        .cf_update_done  (cf_update_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction
    // record forms are a signed compare of the result with zero
    function automatic cond_pkg::cond_field_t cmp_f(input logic [31:0] a, b,
                                                    input logic sgn, so);
        logic lt;
        lt = sgn ? ($signed(a) < $signed(b)) : (a < b);
        return '{lt, !lt && a != b, a == b, so};
    endfunction
    function automatic cond_pkg::exec_req_t rec(input logic [4:0] a, input logic [31:0] x,
                                                input logic ovf, oe, spc);
        rec         = '0;
        rec.valid   = 1'b1;
        rec.kind    = cond_pkg::OP_RECORD;
        rec.wr_en   = 1'b1;
        rec.wr_addr = a;
        rec.result  = x;
        rec.ovf     = ovf;
        rec.oe      = oe;
        rec.special = spc;
    endfunction
    function automatic cond_pkg::exec_req_t cmpq(input logic uns, input logic [2:0] f,
                                                 input logic [4:0] a, b, input logic im);
        cmpq                     = '0;
        cmpq.valid               = 1'b1;
        cmpq.kind                = uns ? cond_pkg::OP_CMP_UNS : cond_pkg::OP_CMP_SGN;
        cmpq.target_field_select = f;
        cmpq.src_a               = a;
        cmpq.src_b               = b;
        cmpq.use_imm             = im;
        cmpq.imm                 = 32'hffff_ffff;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // drive one cycle shortly after the edge; the read port wanders at random
    task automatic issue(input cond_pkg::exec_req_t q, input logic clr);
        @(posedge clock);
        #1;
        cmd         = q;
        so_clear    = clr;
        gpr_rd_addr = lfsr_q[4:0];
        lfsr_q      = lfsr_next(lfsr_q);
    endtask
    // random request; oe only on record forms, whose overflow the bench can reason about
    task automatic gen(output cond_pkg::exec_req_t q, output logic clr);
        logic [31:0] b;
        b                     = lfsr_q;
        lfsr_q                = lfsr_next(lfsr_q);
        q                     = '0;
        q.valid               = b[28] | b[29];
        q.kind                = cond_pkg::op_kind_t'(4'h1 << b[1:0]);
        q.special             = b[2] & b[3];
        q.wr_en               = b[4];
        q.wr_addr             = b[9:5];
        q.ovf                 = b[10];
        q.oe                  = b[11] && q.kind == cond_pkg::OP_RECORD;
        q.target_field_select = b[14:12];
        q.src_a               = b[19:15];
        q.src_b               = b[24:20];
        q.use_imm             = b[25];
        q.result              = b[26] ? {b[27], 31'h0000_0000} : lfsr_q;
        q.imm                 = ~lfsr_q;
        clr                   = b[30] & b[31];
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // reference pipeline: take at one edge, flags at the next; set wins over clear
    always @(posedge clock) begin
        if (!rst_n) begin
            cf_m     = '0;
            so_m     = 1'b0;
            ovr_m    = 1'b0;
            done_m   = 1'b0;
            rd_m     = '0;
            rd_known = 1'b1;
            s1       = '0;
        end else begin
            so_m   = (s1.valid & s1.oe & s1.ovf) | (so_m & ~so_clear);
            done_m = 1'b0;
            if (s1.valid && s1.oe) ovr_m = s1.ovf;
            if (s1.valid && s1.kind == cond_pkg::OP_RECORD && !s1.special) begin
                cf_m[0] = cmp_f(s1.result, 32'h0000_0000, 1'b1, so_m);
                done_m  = 1'b1;
            end
            if (s1.valid && s1.kind inside {cond_pkg::OP_CMP_SGN, cond_pkg::OP_CMP_UNS}) begin
                cf_m[s1.target_field_select] =
                    cmp_f(s1_a, s1_b, s1.kind == cond_pkg::OP_CMP_SGN, so_m);
                done_m = 1'b1;
            end
            s1 = exec_req;
            if (exec_req.valid && exec_req.wr_en) begin
                gpr_m[exec_req.wr_addr]   = exec_req.result;
                known_m[exec_req.wr_addr] = 1'b1;
            end
            s1_a     = gpr_m[exec_req.src_a];
            s1_b     = exec_req.use_imm ? exec_req.imm : gpr_m[exec_req.src_b];
            rd_m     = gpr_m[gpr_rd_addr];
            rd_known = known_m[gpr_rd_addr];
        end
    end
    // every output is compared mid-cycle, once it has settled; gpr_rd_data only where the bench knows the value
    always @(negedge clock) begin
        if (armed) begin
            check("condition_reg", 32'(condition_reg), 32'(cf_m));
            check("upper_fields", 32'(condition_reg[7:1]), 32'(cf_m[7:1]));
            check("less_flag", 32'(condition_reg[0][3]), 32'(cf_m[0][3]));
            check("greater_flag", 32'(condition_reg[0][2]), 32'(cf_m[0][2]));
            check("equal_flag", 32'(condition_reg[0][1]), 32'(cf_m[0][1]));
            check("so_copy", 32'(condition_reg[0][0]), 32'(cf_m[0][0]));
            check("summary_overflow", {31'h0, summary_overflow}, {31'h0, so_m});
            check("overflow_flag", {31'h0, overflow_flag}, {31'h0, ovr_m});
            check("cf_update_done", {31'h0, cf_update_done}, {31'h0, done_m});
            if (rd_known === 1'b1) check("gpr_rd_data", gpr_rd_data, rd_m);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n       = 1'b0;
        cmd         = '0;
        so_clear    = 1'b0;
        gpr_rd_addr = '0;
        lfsr_q      = 32'h3cd8;
        n_mismatch  = 0;
        check_count = 0;
        armed       = 1'b0;
        for (i = 0; i < `GPR_COUNT; i++) known_m[i] = 1'b0;
        @(posedge clock);
        #1 armed = 1'b1;
        repeat (2) @(posedge clock);
        #1 rst_n = 1'b1;
        // fill the array back to back, sign and zero corners first
        for (i = 0; i < `GPR_COUNT; i++) begin
            v = (i == 1) ? 32'h8000_0000 : (i == 2) ? 32'h7fff_ffff : lfsr_q;
            v = (i == 0) ? 32'h0000_0000 : (i == 3) ? 32'hffff_ffff : v;
            issue(rec(i[4:0], v, 1'b0, 1'b0, 1'b0), 1'b0);
        end
        issue(rec(5'h04, 32'h0000_0000, 1'b1, 1'b1, 1'b0), 1'b0); // wrapped sum sets so
        issue(rec(5'h05, 32'h0000_0001, 1'b1, 1'b0, 1'b0), 1'b1); // clear meets set
        issue('0, 1'b1);
        issue(rec(5'h06, 32'h8000_0000, 1'b1, 1'b0, 1'b0), 1'b0); // overflow, no oe
        issue(rec(5'h07, 32'h0000_0000, 1'b0, 1'b0, 1'b1), 1'b0); // own-definition form
        // zero against all ones into every field, signed and unsigned
        for (i = 0; i < 16; i++) issue(cmpq(i[3], i[2:0], 5'h00, 5'h03, i[0]), 1'b0);
        issue('0, 1'b0);
        for (i = 0; i < 4 && cf_update_done !== 1'b1; i++) @(negedge clock);
        if (cf_update_done !== 1'b1) begin
            n_mismatch++;
        end else begin
            for (i = 0; i < 600; i++) begin
                gen(r, c);
                issue(r, c);
            end
        end
        issue('0, 1'b0);
        repeat (3) @(posedge clock);
        end_sim();
    end
endmodule
